// ==== src/pmr_defs.svh ====
/*
 * Register map constants for the management status and test bank:
 * word indices, field positions and reset values.
 * Assumes the includer addresses registers by word index (byte addr / 4).
 */
`ifndef PMR_DEFS_SVH
`define PMR_DEFS_SVH

// ****************************************************************
// Register word indices
// ****************************************************************
`define PMR_IDX_W 10
`define PMR_IDX_GIE 10'h011
`define PMR_IDX_EVT 10'h018
`define PMR_IDX_ADDR 10'h019
`define PMR_IDX_TDR 10'h01E
`define PMR_IDX_RST 10'h01F
`define PMR_IDX_LINK 10'h180
`define PMR_IDX_LPS 10'h18B

// ****************************************************************
// Field positions
// ****************************************************************
`define PMR_EVT_ACK_B 15
`define PMR_EVT_TXV_B 14
`define PMR_EVT_POR_B 11
`define PMR_EVT_ACK_EN_B 7
`define PMR_EVT_TXV_EN_B 6
`define PMR_EVT_POR_EN_B 3
`define PMR_GIE_B 1
`define PMR_TDR_START_B 15
`define PMR_TDR_AUTO_B 14
`define PMR_TDR_DONE_B 1
`define PMR_TDR_FAIL_B 0
`define PMR_RST_FULL_B 15
`define PMR_RST_CORE_B 14
`define PMR_LPS_ED_B 8
`define PMR_LPS_SLEEP_B 7
`define PMR_LINK_UP_B 15
`define PMR_LINK_DOWN_B 14
`define PMR_LINK_SEND_B 13
`define PMR_LINK_LIVE_B 12
`define PMR_LINK_CHAN_B 3
`define PMR_LINK_DLOCK_B 2
`define PMR_LINK_LOC_B 1
`define PMR_LINK_REM_B 0
`define PMR_ADDR_W 5

// ****************************************************************
// Reset values and the strap sync fill count
// ****************************************************************
`define PMR_EVT_EN_RESET 3'b001
`define PMR_GIE_RESET 1'b1
`define PMR_FILL_DONE 2'h3

`endif

// ==== src/pmr_pkg.sv ====
/*
 * Types shared by the management status and test bank.
 * Assumes pmr_defs.svh supplies the numeric constants.
 */
package pmr_pkg;

	// Summary flags coming from the link control state machine
	typedef struct packed {
		logic link_up;
		logic link_down;
		logic send_data;
		logic live_link;
		logic channel_ok;
		logic descr_lock;
		logic loc_rcvr;
		logic rem_rcvr;
	} pmr_link_stat_t;

	// Cable test progress as software sees it
	typedef struct packed {
		logic busy;
		logic done;
		logic fail;
	} pmr_tdr_stat_t;

	typedef enum logic [1:0] {
		PMR_TDR_IDLE = 2'b00,
		PMR_TDR_RUN = 2'b01
	} pmr_tdr_state_t;

endpackage : pmr_pkg

// ==== src/pmr_strap_sync.sv ====
/*
 * Three-flop synchroniser for the station address straps.
 * Assumes straps are slow levels from pins, asynchronous to clk_i.
 */
`timescale 1ns/1ps
`include "pmr_defs.svh"

module pmr_strap_sync
	import pmr_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Pin side
	input wire logic [`PMR_ADDR_W-1:0] strap_i,
	// Synchronised side
	output logic [`PMR_ADDR_W-1:0] q_o,
	output logic valid_o
);

	logic [`PMR_ADDR_W-1:0] s1_r;
	logic [`PMR_ADDR_W-1:0] s2_r;
	logic [`PMR_ADDR_W-1:0] s3_r;
	logic [1:0] fill_r;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= strap_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// A change counts only once stages two and three agree
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			q_o <= '0;
		end else if (s2_r == s3_r) begin
			q_o <= s3_r;
		end
	end

	// Reset zeros are not strap values; wait for the pipe to fill
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			fill_r <= 2'h0;
			valid_o <= 1'b0;
		end else if (fill_r != `PMR_FILL_DONE) begin
			fill_r <= fill_r + 2'h1;
		end else begin
			valid_o <= 1'b1;
		end
	end

endmodule : pmr_strap_sync

// ==== src/pmr_cable_test.sv ====
/*
 * Cable reflectometry test sequencer: starts a measurement run on
 * request or on link loss, and holds the done and fail results.
 * Assumes the measurement engine pulses meas_done_i with meas_fail_i.
 */
`timescale 1ns/1ps
`include "pmr_defs.svh"

module pmr_cable_test
	import pmr_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic core_rst_i,
	// Control
	input wire logic start_i,
	input wire logic auto_run_i,
	input wire logic link_down_i,
	// Measurement engine
	input wire logic meas_done_i,
	input wire logic meas_fail_i,
	output logic meas_run_o,
	// Status
	output pmr_tdr_stat_t stat_o
);

	pmr_tdr_state_t state_r;
	logic link_down_d_r;
	logic auto_go;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			link_down_d_r <= 1'b0;
		end else begin
			link_down_d_r <= link_down_i;
		end
	end

	assign auto_go = auto_run_i && link_down_i && !link_down_d_r;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= PMR_TDR_IDLE;
			meas_run_o <= 1'b0;
			stat_o <= '0;
		end else if (core_rst_i) begin
			state_r <= PMR_TDR_IDLE;
			meas_run_o <= 1'b0;
			stat_o <= '0;
		end else begin
			case (state_r)
				PMR_TDR_IDLE: begin
					if (start_i || auto_go) begin
						state_r <= PMR_TDR_RUN;
						meas_run_o <= 1'b1;
						stat_o <= '{busy: 1'b1, done: 1'b0, fail: 1'b0};
					end
				end
				PMR_TDR_RUN: begin
					if (meas_done_i) begin
						state_r <= PMR_TDR_IDLE;
						meas_run_o <= 1'b0;
						stat_o.busy <= 1'b0;
						stat_o.done <= 1'b1;
						stat_o.fail <= meas_fail_i;
					end
				end
				default: begin
					state_r <= PMR_TDR_IDLE;
					meas_run_o <= 1'b0;
					stat_o <= '0;
				end
			endcase
		end
	end

endmodule : pmr_cable_test

// ==== src/pmr_regs.sv ====
/*
 * Management status and test register bank on a classic Wishbone
 * slave: event interrupts, strapped station address, cable test
 * control, soft resets and the link state summary.
 * Assumes event, link and measurement inputs come from logic on clk_i,
 * and only the straps come from pins.
 */
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`include "pmr_defs.svh"

module pmr_regs
	import pmr_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Event pulses from the core
	input wire logic oam_ack_rcvd_i,
	input wire logic oam_tx_valid_clr_i,
	input wire logic por_done_i,
	// Strap pins
	input wire logic [`PMR_ADDR_W-1:0] strap_addr_i,
	// Link control state machine summary
	input wire pmr_link_stat_t link_stat_i,
	// Cable measurement engine
	input wire logic tdr_meas_done_i,
	input wire logic tdr_meas_fail_i,
	output logic tdr_meas_run_o,
	// Core controls and interrupt
	output logic core_reset_o,
	output logic energy_det_en_o,
	output logic sleep_en_o,
	output logic irq_o
);

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	logic req;
	logic wr_go;
	logic [`PMR_IDX_W-1:0] idx;
	logic [15:0] wmask;
	logic [15:0] wdat;
	logic [15:0] rdat;

	assign req = wb_cyc_i && wb_stb_i;
	// Word index; the two low address bits are ignored
	assign idx = wb_adr_i[11:2];
	assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wdat = wb_dat_i[15:0] & wmask;
	// Writes land at the edge where the master samples ack
	assign wr_go = req && wb_we_i && wb_ack_o;

	// Helpers: a field is written only when its byte lane is enabled
	function automatic logic lane_on(input logic [15:0] m, input int b);
		lane_on = m[b];
	endfunction : lane_on

	// ****************************************************************
	// Soft reset commands
	// ****************************************************************
	logic full_soft_reset_bit_r;
	logic core_rst_r;
	logic rst_wr;

	// Full reset also fires the core reset, so a running test aborts
	assign rst_wr = wr_go && (idx == `PMR_IDX_RST);

	// Self-clearing: each command lives for exactly one cycle
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			full_soft_reset_bit_r <= 1'b0;
			core_rst_r <= 1'b0;
		end else begin
			full_soft_reset_bit_r <= rst_wr && wdat[`PMR_RST_FULL_B];
			core_rst_r <= rst_wr && (wdat[`PMR_RST_CORE_B]
				|| wdat[`PMR_RST_FULL_B]);
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			core_reset_o <= 1'b0;
		end else begin
			core_reset_o <= core_rst_r;
		end
	end

	// ****************************************************************
	// Event status and enables
	// ****************************************************************
	logic [2:0] evt_set;
	logic [2:0] evt_st_r;
	logic [2:0] evt_en_r;
	logic [2:0] evt_clr;
	logic evt_wr;
	logic gie_r;

	assign evt_wr = wr_go && (idx == `PMR_IDX_EVT);
	assign evt_set = {oam_ack_rcvd_i, oam_tx_valid_clr_i, por_done_i};
	// Status bits clear by writing one; enables need the low lane
	assign evt_clr = evt_wr ? {wdat[`PMR_EVT_ACK_B], wdat[`PMR_EVT_TXV_B],
		wdat[`PMR_EVT_POR_B]} : 3'b000;

	// A new event in the clearing cycle survives the clear
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			evt_st_r <= 3'b000;
		end else if (full_soft_reset_bit_r) begin
			evt_st_r <= 3'b000;
		end else begin
			evt_st_r <= (evt_st_r & ~evt_clr) | evt_set;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			evt_en_r <= `PMR_EVT_EN_RESET;
		end else if (full_soft_reset_bit_r) begin
			evt_en_r <= `PMR_EVT_EN_RESET;
		end else if (evt_wr && lane_on(wmask, 0)) begin
			evt_en_r <= {wdat[`PMR_EVT_ACK_EN_B], wdat[`PMR_EVT_TXV_EN_B],
				wdat[`PMR_EVT_POR_EN_B]};
		end
	end

	// Global enable lives apart from the event word
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			gie_r <= `PMR_GIE_RESET;
		end else if (full_soft_reset_bit_r) begin
			gie_r <= `PMR_GIE_RESET;
		end else if (wr_go && (idx == `PMR_IDX_GIE) && lane_on(wmask, 0)) begin
			gie_r <= wdat[`PMR_GIE_B];
		end
	end

	// Level output; stays high until software clears the cause, its enable or gie_r
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= gie_r && |(evt_st_r & evt_en_r);
		end
	end

	// ****************************************************************
	// Strapped station address
	// ****************************************************************
	logic [`PMR_ADDR_W-1:0] strap_q;
	logic strap_vld;
	logic strap_taken_r;
	logic [`PMR_ADDR_W-1:0] strapped_station_addr_r;

	// Straps are pins: they cross through three flops first
	pmr_strap_sync u_strap_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.strap_i(strap_addr_i),
		.q_o(strap_q),
		.valid_o(strap_vld)
	);

	// Caught once after power-up; later strap movement is ignored
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			strap_taken_r <= 1'b0;
			strapped_station_addr_r <= '0;
		end else if (strap_vld && !strap_taken_r) begin
			strap_taken_r <= 1'b1;
			strapped_station_addr_r <= strap_q;
		end
	end

	// ****************************************************************
	// Cable test control
	// ****************************************************************
	logic tdr_auto_r;
	logic tdr_wr;
	logic tdr_start;
	pmr_tdr_stat_t tdr_stat;

	// Both control bits sit in the high byte lane
	assign tdr_wr = wr_go && (idx == `PMR_IDX_TDR) && lane_on(wmask, 8);
	// Writing one while a run is busy is ignored by the sequencer
	assign tdr_start = tdr_wr && wdat[`PMR_TDR_START_B];

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			tdr_auto_r <= 1'b0;
		end else if (full_soft_reset_bit_r) begin
			tdr_auto_r <= 1'b0;
		end else if (tdr_wr) begin
			tdr_auto_r <= wdat[`PMR_TDR_AUTO_B];
		end
	end

	// Auto-run reacts to link-down edges only, not to a held level
	pmr_cable_test u_cable_test (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.core_rst_i(core_rst_r),
		.start_i(tdr_start),
		.auto_run_i(tdr_auto_r),
		.link_down_i(link_stat_i.link_down),
		.meas_done_i(tdr_meas_done_i),
		.meas_fail_i(tdr_meas_fail_i),
		.meas_run_o(tdr_meas_run_o),
		.stat_o(tdr_stat)
	);

	// ****************************************************************
	// Link summary and low-power configuration
	// ****************************************************************
	pmr_link_stat_t link_r;

	// One register stage so a read sees a coherent snapshot
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			link_r <= '0;
		end else begin
			link_r <= link_stat_i;
		end
	end

	// Low-power bits only hold their value for the core
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			energy_det_en_o <= 1'b0;
		end else if (full_soft_reset_bit_r) begin
			energy_det_en_o <= 1'b0;
		end else if (wr_go && (idx == `PMR_IDX_LPS) && lane_on(wmask, 8)) begin
			energy_det_en_o <= wdat[`PMR_LPS_ED_B];
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sleep_en_o <= 1'b0;
		end else if (full_soft_reset_bit_r) begin
			sleep_en_o <= 1'b0;
		end else if (wr_go && (idx == `PMR_IDX_LPS) && lane_on(wmask, 0)) begin
			sleep_en_o <= wdat[`PMR_LPS_SLEEP_B];
		end
	end

	// ****************************************************************
	// Read mux and bus answer
	// ****************************************************************
	// Reserved and unmapped bits read as zero
	always_comb begin
		rdat = 16'h0000;
		case (idx)
			`PMR_IDX_GIE: begin
				rdat[`PMR_GIE_B] = gie_r;
			end
			`PMR_IDX_EVT: begin
				rdat[`PMR_EVT_ACK_B] = evt_st_r[2];
				rdat[`PMR_EVT_TXV_B] = evt_st_r[1];
				rdat[`PMR_EVT_POR_B] = evt_st_r[0];
				rdat[`PMR_EVT_ACK_EN_B] = evt_en_r[2];
				rdat[`PMR_EVT_TXV_EN_B] = evt_en_r[1];
				rdat[`PMR_EVT_POR_EN_B] = evt_en_r[0];
			end
			`PMR_IDX_ADDR: begin
				rdat[`PMR_ADDR_W-1:0] = strapped_station_addr_r;
			end
			`PMR_IDX_TDR: begin
				rdat[`PMR_TDR_START_B] = tdr_stat.busy;
				rdat[`PMR_TDR_AUTO_B] = tdr_auto_r;
				rdat[`PMR_TDR_DONE_B] = tdr_stat.done;
				rdat[`PMR_TDR_FAIL_B] = tdr_stat.fail;
			end
			`PMR_IDX_RST: begin
				rdat[`PMR_RST_FULL_B] = full_soft_reset_bit_r;
				rdat[`PMR_RST_CORE_B] = core_rst_r;
			end
			`PMR_IDX_LINK: begin
				rdat[`PMR_LINK_UP_B] = link_r.link_up;
				rdat[`PMR_LINK_DOWN_B] = link_r.link_down;
				rdat[`PMR_LINK_SEND_B] = link_r.send_data;
				rdat[`PMR_LINK_LIVE_B] = link_r.live_link;
				rdat[`PMR_LINK_CHAN_B] = link_r.channel_ok;
				rdat[`PMR_LINK_DLOCK_B] = link_r.descr_lock;
				rdat[`PMR_LINK_LOC_B] = link_r.loc_rcvr;
				rdat[`PMR_LINK_REM_B] = link_r.rem_rcvr;
			end
			`PMR_IDX_LPS: begin
				rdat[`PMR_LPS_ED_B] = energy_det_en_o;
				rdat[`PMR_LPS_SLEEP_B] = sleep_en_o;
			end
			default: begin
				rdat = 16'h0000;
			end
		endcase
	end

	// Every access, mapped or not, gets ack one cycle after the request
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req && !wb_ack_o;
		end
	end

	// Read data holds until the next read
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (req && !wb_ack_o && !wb_we_i) begin
			wb_dat_o <= {16'h0000, rdat};
		end
	end

endmodule : pmr_regs

// ==== tb/pmr_regs_props.sv ====
/* Concurrent checks on the pmr_regs ports: bus answer, read data,
 * soft reset pulse, cable test run and interrupt causes.
 * Assumes it is bound to every pmr_regs instance. */
`timescale 1ns/1ps
module pmr_regs_props (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Events, test and controls
	input wire logic oam_ack_rcvd_i,
	input wire logic oam_tx_valid_clr_i,
	input wire logic por_done_i,
	input wire logic tdr_meas_done_i,
	input wire logic tdr_meas_run_o,
	input wire logic core_reset_o,
	input wire logic irq_o
);
	logic wr;
	logic mapped;
	logic ev;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// A write lands only at the acked edge
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign ev = oam_ack_rcvd_i || oam_tx_valid_clr_i || por_done_i;
	assign mapped = wb_adr_i[11:2] inside {10'h011, 10'h018, 10'h019,
		10'h01E, 10'h01F, 10'h180, 10'h18B};
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	chk_ack_answer: assert property
		(wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	chk_dat_upper: assert property (wb_dat_o[31:16] == 16'h0000)
		else $error("upper read data not zero");
	chk_unmapped_zero: assert property
		(wb_ack_o && !wb_we_i && !mapped |-> wb_dat_o == 32'h00000000)
		else $error("unmapped read not zero");
	chk_core_cmd: assert property
		(wr && wb_adr_i[11:2] == 10'h01F && wb_sel_i[1] &&
		(wb_dat_i[15] || wb_dat_i[14]) |-> ##[1:2] core_reset_o)
		else $error("soft reset command gave no core reset");
	chk_core_single: assert property (core_reset_o |=> !core_reset_o)
		else $error("core reset longer than one cycle");
	chk_run_start: assert property
		(wr && wb_adr_i[11:2] == 10'h01E && wb_sel_i[1] && wb_dat_i[15]
		&& !tdr_meas_run_o |-> ##[1:2] tdr_meas_run_o)
		else $error("cable test did not start");
	chk_run_stop: assert property
		(tdr_meas_run_o && tdr_meas_done_i |=> !tdr_meas_run_o)
		else $error("cable test kept running after done");
	chk_irq_fall: assert property
		($fell(irq_o) |-> $past(wr, 2) || $past(wr, 3))
		else $error("interrupt dropped without a write");
	chk_irq_cause: assert property
		($rose(irq_o) |-> $past(ev, 2) || $past(wr, 2))
		else $error("interrupt rose without cause");
	cover property (por_done_i ##2 irq_o);
	cover property (core_reset_o);
	cover property (tdr_meas_run_o && tdr_meas_done_i);
endmodule : pmr_regs_props

bind pmr_regs pmr_regs_props u_props (.clk_i(clk_i), .reset_i(reset_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.oam_ack_rcvd_i(oam_ack_rcvd_i), .oam_tx_valid_clr_i(oam_tx_valid_clr_i),
	.por_done_i(por_done_i), .tdr_meas_done_i(tdr_meas_done_i),
	.tdr_meas_run_o(tdr_meas_run_o), .core_reset_o(core_reset_o),
	.irq_o(irq_o));

// ==== tb/tb_pmr_regs.sv ====
/* Self-checking bench for pmr_regs: registers, events, cable test
 * and soft resets over classic Wishbone, with seeded random data.
 * Assumes pmr_regs_props is compiled alongside. */
`timescale 1ns/1ps
module tb_pmr_regs;
	import pmr_pkg::*;
	logic clk_i = 0, reset_i = 1, cyc = 0, stb = 0, we = 0;
	logic [11:0] adr = 12'h000;
	logic [3:0] sel = 4'h0;
	logic [3:0] wsel = 4'hF;
	logic [31:0] dat = 32'h0, wb_dat_o, r, seed = 32'h00000054;
	logic wb_ack_o, mdone = 0, mfail = 0, run, core_rst, irq, seen;
	logic ed, slp;
	logic [2:0] evt = 3'h0;
	logic [4:0] strap = 5'h00;
	logic [15:0] q;
	pmr_link_stat_t lnk = '0;
	int error_cnt = 0, n_checks = 0, cycles = 0;
	always #12.5 clk_i = ~clk_i;
	pmr_regs uut (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.oam_ack_rcvd_i(evt[2]), .oam_tx_valid_clr_i(evt[1]),
		.por_done_i(evt[0]), .strap_addr_i(strap), .link_stat_i(lnk),
		.tdr_meas_done_i(mdone), .tdr_meas_fail_i(mfail),
		.tdr_meas_run_o(run), .core_reset_o(core_rst),
		.energy_det_en_o(ed), .sleep_en_o(slp), .irq_o(irq));
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function automatic logic [15:0] evb(input int i);
		return (i == 0) ? 16'h8000 : (i == 1) ? 16'h4000 : 16'h0800;
	endfunction : evb
	function automatic logic [15:0] exp_lnk(input logic [7:0] l);
		return {l[7:4], 8'h00, l[3:0]};
	endfunction : exp_lnk
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : tally_and_finish
	task automatic wb(input logic w, input logic [9:0] ix, input logic [15:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1; stb <= 1; we <= w; adr <= {ix, 2'b00}; sel <= wsel;
		dat <= {16'h0000, d};
		n = 0;
		do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 40);
		if (wb_ack_o !== 1'b1) begin
			error_cnt++;
			$display("BAD ack exp 1 got %b", wb_ack_o);
		end
		q = wb_dat_o[15:0];
		cyc <= 0; stb <= 0; we <= 0;
	endtask : wb
	task automatic chk_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin error_cnt++; $display("BAD %s exp %h got %h", nm, e, g); end
	endtask : chk_reg
	task automatic chk_bit(input string nm, input logic e, input logic g);
		n_checks++;
		if (g !== e) begin error_cnt++; $display("BAD %s exp %b got %b", nm, e, g); end
	endtask : chk_bit
	task automatic rd_chk(input string nm, input logic [9:0] ix, input logic [15:0] e);
		wb(1'b0, ix, 16'h0000);
		chk_reg(nm, e, q);
	endtask : rd_chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick
	task automatic pulse_ev(input int i);
		@(posedge clk_i); evt <= 3'b100 >> i;
		@(posedge clk_i); evt <= 3'b000;
	endtask : pulse_ev
	task automatic meas(input logic f);
		@(posedge clk_i); mdone <= 1; mfail <= f;
		@(posedge clk_i); mdone <= 0;
	endtask : meas
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin error_cnt++; tally_and_finish(); end
	end
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		r = xs(); strap = r[4:0];
		repeat (8) @(posedge clk_i);
		reset_i <= 0;
		tick(10);
		rd_chk("evt_rst", 10'h018, 16'h0008);
		rd_chk("tdr_rst", 10'h01E, 16'h0000);
		rd_chk("cmd_rst", 10'h01F, 16'h0000);
		rd_chk("strap", 10'h019, {11'h000, strap});
		wb(1'b0, 10'h011, 16'h0000); chk_bit("gie_rst", 1'b1, q[1]);
		wb(1'b1, 10'h3FF, 16'hFFFF);
		rd_chk("unmapped", 10'h3FF, 16'h0000);
		for (int k = 0; k < 6; k++) begin
			r = xs(); lnk <= r[7:0]; tick(3);
			rd_chk("link", 10'h180, exp_lnk(r[7:0]));
		end
		for (int i = 0; i < 3; i++) begin
			wb(1'b1, 10'h018, evb(i) >> 8);
			pulse_ev(i); tick(3); chk_bit("irq_on", 1'b1, irq);
			rd_chk("evt_set", 10'h018, evb(i) | (evb(i) >> 8));
			wb(1'b1, 10'h018, evb(i)); tick(3); chk_bit("irq_clr", 1'b0, irq);
			pulse_ev(i); tick(3); chk_bit("irq_mask", 1'b0, irq);
			rd_chk("evt_mask", 10'h018, evb(i));
			wb(1'b1, 10'h018, evb(i));
		end
		wb(1'b1, 10'h011, 16'h0000); wb(1'b1, 10'h018, 16'h0008);
		pulse_ev(2); tick(3); chk_bit("irq_gie0", 1'b0, irq);
		wb(1'b1, 10'h011, 16'h0002); tick(3); chk_bit("irq_gie1", 1'b1, irq);
		wb(1'b1, 10'h018, 16'h0808); tick(3); chk_bit("irq_off", 1'b0, irq);
		for (int k = 0; k < 4; k++) begin
			r = xs(); r[0] = k[0];
			wb(1'b1, 10'h01E, 16'h8000); tick(3); chk_bit("run", 1'b1, run);
			rd_chk("tdr_busy", 10'h01E, 16'h8000);
			meas(r[0]); tick(2); chk_bit("run_end", 1'b0, run);
			rd_chk("tdr_done", 10'h01E, {14'h0000, 1'b1, r[0]});
		end
		lnk <= '0;
		wb(1'b1, 10'h01E, 16'h4000); lnk.link_down <= 1;
		tick(3); chk_bit("auto_run", 1'b1, run);
		meas(1'b0); lnk.link_down <= 0;
		wb(1'b1, 10'h01E, 16'h0000); lnk.link_down <= 1;
		tick(3); chk_bit("no_auto", 1'b0, run);
		wb(1'b1, 10'h01E, 16'h8000); wb(1'b1, 10'h018, 16'h00C8);
		wb(1'b1, 10'h01F, 16'h4000);
		seen = 0;
		repeat (5) begin @(posedge clk_i); #1; seen |= core_rst; end
		chk_bit("core_rst", 1'b1, seen);
		chk_bit("run_abort", 1'b0, run);
		rd_chk("evt_kept", 10'h018, 16'h00C8);
		rd_chk("tdr_clr", 10'h01E, 16'h0000);
		rd_chk("core_sc", 10'h01F, 16'h0000);
		wsel = 4'h1;
		wb(1'b1, 10'h18B, 16'h0180);
		wsel = 4'hF;
		rd_chk("lps_lane", 10'h18B, 16'h0080);
		wb(1'b1, 10'h18B, 16'h0180);
		tick(2);
		chk_bit("ed_on", 1'b1, ed);
		chk_bit("sleep_on", 1'b1, slp);
		rd_chk("lps_set", 10'h18B, 16'h0180);
		wb(1'b1, 10'h011, 16'h0000);
		wb(1'b1, 10'h01E, 16'h4000); wb(1'b1, 10'h01F, 16'h8000); tick(4);
		rd_chk("evt_full", 10'h018, 16'h0008);
		rd_chk("tdr_full", 10'h01E, 16'h0000);
		rd_chk("full_sc", 10'h01F, 16'h0000);
		rd_chk("strap_kept", 10'h019, {11'h000, strap});
		rd_chk("lps_full", 10'h18B, 16'h0000);
		chk_bit("ed_full", 1'b0, ed);
		chk_bit("sleep_full", 1'b0, slp);
		wb(1'b0, 10'h011, 16'h0000);
		chk_bit("gie_full", 1'b1, q[1]);
		tally_and_finish();
	end
endmodule : tb_pmr_regs
